// ==== hdl/lpc_io_wake.sv ====
// Coprocessor I/O operation decoder with the sleep and wake sequencer.
//
// Summary of operation
// - Opcode 5 measures; select bit 0 uses converter one, 1 converter two.
// - Pad field 1..10 enables converter input field minus one.
// - Measurement result goes to the general register named by destination field.
// - Serial target address comes from slot field of eight slots; index sent as sub-address.
// - Direction 1 writes, 0 reads; data byte sent only on writes.
// - Incoming serial data is sampled on the falling edge of serial clock.
// - Opcode 2 read loads bits High..Low of addressed register into register zero.
// - Read spans over sixteen bits return Low..Low+15 instead.
// - Peripheral addresses are 10-bit word addresses from the window base.
// - Peripheral accesses reach only the four low-power register groups.
// - Write stores immediate bits 17..10 into High..Low of word at bits 9..0.
// - Write spans over eight bits are padded with zeros above the eighth bit.
// - Stop puts the coprocessor to sleep and restarts the slow tick wake timer.
// - On timer expiry power up and start at the start address value.
// - After reset the first start waits for period slot zero.
// - Timer runs only while enabled; bus or program may clear the enable.
// - Waking after expiry takes two clock cycles.
// - After waking, wait the settle count before running the program.
// - After stop, two more clock cycles put the coprocessor to sleep.
// - A serial read places the returned byte into general register zero.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module lpc_io_wake
   import lpc_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic [31:0] INSTR_IN,
   output logic [PC_W-1:0] PC_OUT,
   output logic FETCH_OUT,
   output logic AWAKE_OUT,
   output lpc_periph_req_t PERIPH_REQ_OUT,
   input wire logic PERIPH_ACK_IN,
   input wire logic [31:0] PERIPH_RDATA_IN,
   output lpc_meas_req_t MEAS_REQ_OUT,
   input wire logic MEAS_DONE_IN,
   input wire logic [15:0] MEAS_RESULT_IN,
   output lpc_serial_req_t SERIAL_REQ_OUT,
   input wire logic SERIAL_DONE_IN,
   input wire logic SLOW_TICK_IN,
   input wire logic SCL_IN,
   input wire logic SDA_IN
);

   ////////////////////////////////////////////////////////////////////////////
   lpc_state_t state;
   lpc_kind_t kind;
   logic [PC_W-1:0] pc;
   logic [1:0] dst;
   logic ctrl_en;
   logic [2:0] period_sel;
   logic [PC_W-1:0] start_pc;
   logic [CNT_W-1:0] settle_wait;
   logic [CNT_W-1:0] period_slot [N_PERIOD];
   logic [6:0] target_slot [N_TARGET];
   logic [15:0] greg [N_GREG];
   logic [CNT_W-1:0] tick_cnt;
   logic [CNT_W-1:0] settle_cnt;
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] sync_c;
   logic [2:0] stable;
   logic [8:0] rx_shift;
   logic wr_pend;
   logic [7:0] wr_ofs;

   logic [3:0] opc;
   logic [2:0] sub;
   logic [4:0] fld_high;
   logic [4:0] fld_low;
   logic [3:0] pad;
   logic tick_edge;
   logic scl_fall;
   logic wake_expire;
   logic settle_done;
   logic done_now;
   logic prog_ctrl_wr;
   logic [31:0] wr_mask;
   logic [31:0] wr_data;
   logic [15:0] rd_value;
   logic ahb_take;

   assign opc = INSTR_IN[OPC_HI:OPC_LO];
   assign sub = INSTR_IN[SUB_HI:SUB_LO];
   assign fld_high = INSTR_IN[PR_HIGH_HI:PR_HIGH_LO];
   assign fld_low = INSTR_IN[PR_LOW_HI:PR_LOW_LO];
   assign pad = INSTR_IN[MEAS_PAD_HI:MEAS_PAD_LO];

   // Mask of bits high..low; an inverted range selects nothing.
   function automatic logic [31:0] span_mask(input logic [4:0] hi, input logic [4:0] lo);
      logic [31:0] m;
      m = (32'hFFFFFFFF >> (5'h1F - hi)) & (32'hFFFFFFFF << lo);
      return m;
   endfunction

   // Write data keeps only the eight immediate bits, so higher span bits land as zero.
   assign wr_mask = span_mask(fld_high, fld_low);
   assign wr_data = ({24'h000000, INSTR_IN[PR_IMM_HI:PR_IMM_LO]} << fld_low) & wr_mask;

   // Read result for the instruction held while waiting; the span is capped at sixteen bits.
   logic [31:0] rd_shift;
   logic [5:0] rd_span;
   logic [5:0] rd_lim;
   logic [4:0] rd_high;
   logic [4:0] rd_low;
   logic [31:0] held_instr;
   assign rd_high = held_instr[PR_HIGH_HI:PR_HIGH_LO];
   assign rd_low = held_instr[PR_LOW_HI:PR_LOW_LO];
   assign rd_shift = PERIPH_RDATA_IN >> rd_low;
   assign rd_span = (rd_high >= rd_low) ? ({1'b0, rd_high} - {1'b0, rd_low} + 6'h01) : 6'h00;
   assign rd_lim = (rd_span > RD_SPAN_MAX) ? RD_SPAN_MAX : rd_span;
   assign rd_value = rd_shift[15:0] & 16'((17'h00001 << rd_lim) - 17'h00001);

   ////////////////////////////////////////////////////////////////////////////
   // Pin inputs: three flops, a change counts once stages two and three agree.
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
         sync_c <= 3'h0;
         stable <= 3'h0;
      end else begin
         sync_a <= {SDA_IN, SCL_IN, SLOW_TICK_IN};
         sync_b <= sync_a;
         sync_c <= sync_b;
         stable <= stable ^ ((sync_b ~^ sync_c) & (sync_b ^ stable));
      end
   end

   assign tick_edge = (sync_b[0] == sync_c[0]) && sync_b[0] && !stable[0];
   assign scl_fall = (sync_b[1] == sync_c[1]) && !sync_b[1] && stable[1];

   // The serial master drives the wires; this block keeps its own record of the returned bits.
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rx_shift <= 9'h000;
      end else if (SERIAL_REQ_OUT.start) begin
         rx_shift <= 9'h000;
      end else if (scl_fall) begin
         rx_shift <= {rx_shift[7:0], stable[2]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake timer and settle counter.
   assign wake_expire = (state == ST_SLEEP) && ctrl_en && tick_edge &&
                        (({1'b0, tick_cnt} + 17'h00001) >= {1'b0, period_slot[period_sel]});
   assign settle_done = settle_cnt >= settle_wait;

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         tick_cnt <= '0;
         settle_cnt <= '0;
      end else begin
         if (state != ST_SLEEP || wake_expire) begin
            tick_cnt <= '0;
         end else if (ctrl_en && tick_edge) begin
            tick_cnt <= tick_cnt + 16'h0001;
         end
         if (state == ST_SETTLE) begin
            settle_cnt <= settle_cnt + 16'h0001;
         end else begin
            settle_cnt <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   always_comb begin
      case (kind)
         OP_MEAS: done_now = MEAS_DONE_IN;
         OP_SERIAL: done_now = SERIAL_DONE_IN;
         default: done_now = PERIPH_ACK_IN;
      endcase
   end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state <= ST_SLEEP;
         pc <= '0;
         PC_OUT <= '0;
         kind <= OP_MEAS;
         dst <= 2'h0;
         held_instr <= '0;
      end else begin
         case (state)
            ST_SLEEP: if (wake_expire) state <= ST_WAKE_A;
            ST_WAKE_A: state <= ST_WAKE_B;
            ST_WAKE_B: state <= ST_SETTLE;
            ST_SETTLE: begin
               if (settle_done) begin
                  state <= ST_FETCH;
                  pc <= start_pc;
                  PC_OUT <= start_pc;
               end
            end
            ST_FETCH: state <= ST_EXEC;
            ST_EXEC: begin
               held_instr <= INSTR_IN;
               dst <= INSTR_IN[DST_HI:DST_LO];
               if (opc == OPC_STOP) begin
                  state <= ST_STOP_A;
               end else if (opc == OPC_MEASURE && pad >= PAD_FIRST && pad <= PAD_LAST) begin
                  kind <= OP_MEAS;
                  state <= ST_WAIT;
               end else if (opc == OPC_SERIAL) begin
                  kind <= OP_SERIAL;
                  state <= ST_WAIT;
               end else if (opc == OPC_REG_RD || opc == OPC_REG_WR) begin
                  kind <= OP_PERIPH;
                  state <= ST_WAIT;
               end else begin
                  pc <= pc + 11'h001;
                  PC_OUT <= pc + 11'h001;
                  state <= ST_FETCH;
               end
            end
            ST_WAIT: begin
               if (done_now) begin
                  pc <= pc + 11'h001;
                  PC_OUT <= pc + 11'h001;
                  state <= ST_FETCH;
               end
            end
            ST_STOP_A: state <= ST_STOP_B;
            ST_STOP_B: state <= ST_SLEEP;
            default: state <= ST_SLEEP;
         endcase
      end
   end

   // Fetch handshake and power flag follow the sequencer; instruction is valid one cycle later.
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         FETCH_OUT <= 1'b0;
         AWAKE_OUT <= 1'b0;
      end else begin
         FETCH_OUT <= (state == ST_SETTLE && settle_done) ||
                      (state == ST_EXEC && opc != OPC_STOP && !(opc == OPC_MEASURE &&
                       pad >= PAD_FIRST && pad <= PAD_LAST) && opc != OPC_SERIAL &&
                       opc != OPC_REG_RD && opc != OPC_REG_WR) ||
                      (state == ST_WAIT && done_now);
         AWAKE_OUT <= !(state == ST_SLEEP || state == ST_STOP_B) || wake_expire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request pulses toward converters, serial master and peripheral space.
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         MEAS_REQ_OUT <= '0;
         SERIAL_REQ_OUT <= '0;
         PERIPH_REQ_OUT <= '0;
      end else begin
         MEAS_REQ_OUT.start <= 2'h0;
         SERIAL_REQ_OUT.start <= 1'b0;
         PERIPH_REQ_OUT.wr <= 1'b0;
         PERIPH_REQ_OUT.rd <= 1'b0;
         if (state == ST_EXEC) begin
            if (opc == OPC_MEASURE && pad >= PAD_FIRST && pad <= PAD_LAST) begin
               MEAS_REQ_OUT.start <= INSTR_IN[MEAS_SEL_BIT] ? 2'h2 : 2'h1;
               MEAS_REQ_OUT.pad <= pad - PAD_FIRST;
            end
            if (opc == OPC_SERIAL) begin
               SERIAL_REQ_OUT.start <= 1'b1;
               SERIAL_REQ_OUT.write <= INSTR_IN[SB_DIR_BIT];
               SERIAL_REQ_OUT.addr <= target_slot[INSTR_IN[SB_SLOT_HI:SB_SLOT_LO]];
               SERIAL_REQ_OUT.sub <= INSTR_IN[SB_SUB_HI:SB_SUB_LO];
               SERIAL_REQ_OUT.data <= INSTR_IN[SB_DIR_BIT] ? INSTR_IN[SB_DATA_HI:SB_DATA_LO] : 8'h00;
            end
            if (opc == OPC_REG_RD || opc == OPC_REG_WR) begin
               // The 10-bit word address cannot leave the window of the four low-power groups.
               PERIPH_REQ_OUT.addr <= INSTR_IN[PR_ADDR_HI:PR_ADDR_LO];
               PERIPH_REQ_OUT.rd <= (opc == OPC_REG_RD);
               PERIPH_REQ_OUT.wr <= (opc == OPC_REG_WR);
               PERIPH_REQ_OUT.wdata <= (opc == OPC_REG_WR) ? wr_data : 32'h00000000;
               PERIPH_REQ_OUT.wmask <= (opc == OPC_REG_WR) ? wr_mask : 32'h00000000;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // General registers take results only when the transaction completes.
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         for (int i = 0; i < N_GREG; i++) greg[i] <= '0;
      end else if (state == ST_WAIT && done_now) begin
         if (kind == OP_MEAS) begin
            greg[dst] <= MEAS_RESULT_IN;
         end else if (kind == OP_SERIAL && !held_instr[SB_DIR_BIT]) begin
            // The last bit seen is the master's NACK; the byte precedes it.
            greg[0] <= {8'h00, rx_shift[8:1]};
         end else if (kind == OP_PERIPH && held_instr[OPC_HI:OPC_LO] == OPC_REG_RD) begin
            greg[0] <= rd_value;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY.
   assign ahb_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
   assign prog_ctrl_wr = PERIPH_REQ_OUT.wr && PERIPH_REQ_OUT.addr == CTRL_WORD_ADDR;

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         wr_pend <= 1'b0;
         wr_ofs <= 8'h00;
         HRDATA_OUT <= 32'h00000000;
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT <= 1'b0;
      end else begin
         wr_pend <= ahb_take && HWRITE_IN && HADDR_IN[31:8] == 24'h000000;
         wr_ofs <= HADDR_IN[7:0];
         if (ahb_take && !HWRITE_IN) begin
            HRDATA_OUT <= 32'h00000000;
            if (HADDR_IN[31:8] == 24'h000000) begin
               if (HADDR_IN[7:0] == OFS_CTRL) begin
                  HRDATA_OUT[CTRL_EN_BIT] <= ctrl_en;
                  HRDATA_OUT[CTRL_PSEL_HI:CTRL_PSEL_LO] <= period_sel;
               end
               if (HADDR_IN[7:0] == OFS_START_PC) HRDATA_OUT[PC_W-1:0] <= start_pc;
               if (HADDR_IN[7:0] == OFS_SETTLE) HRDATA_OUT[CNT_W-1:0] <= settle_wait;
               if (HADDR_IN[7:0] == OFS_STATUS) begin
                  HRDATA_OUT[3:0] <= state;
                  HRDATA_OUT[STATUS_PC_LO +: PC_W] <= pc;
               end
               for (int i = 0; i < N_PERIOD; i++) begin
                  if (HADDR_IN[7:0] == OFS_PERIOD0 + 8'(4 * i)) HRDATA_OUT[CNT_W-1:0] <= period_slot[i];
               end
               for (int i = 0; i < N_TARGET; i++) begin
                  if (HADDR_IN[7:0] == OFS_TARGET0 + 8'(4 * i)) HRDATA_OUT[6:0] <= target_slot[i];
               end
               for (int i = 0; i < N_GREG; i++) begin
                  if (HADDR_IN[7:0] == OFS_GREG0 + 8'(4 * i)) HRDATA_OUT[15:0] <= greg[i];
               end
            end
         end
      end
   end

   // Configuration: bus writes win over a program write landing in the same cycle.
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ctrl_en <= 1'b0;
         period_sel <= 3'h0;
         start_pc <= '0;
         settle_wait <= SETTLE_RST;
         for (int i = 0; i < N_PERIOD; i++) period_slot[i] <= PERIOD_RST;
         for (int i = 0; i < N_TARGET; i++) target_slot[i] <= 7'h00;
      end else begin
         if (prog_ctrl_wr) begin
            if (PERIPH_REQ_OUT.wmask[CTRL_EN_BIT]) ctrl_en <= PERIPH_REQ_OUT.wdata[CTRL_EN_BIT];
         end
         if (state == ST_EXEC && opc == OPC_SYS && sub == SYS_SLEEP_SEL &&
             INSTR_IN[SLEEP_SEL_HI:0] < 3'(N_PERIOD)) begin
            period_sel <= INSTR_IN[SLEEP_SEL_HI:0];
         end
         if (wr_pend) begin
            if (wr_ofs == OFS_CTRL) begin
               ctrl_en <= HWDATA_IN[CTRL_EN_BIT];
               if (HWDATA_IN[CTRL_PSEL_HI:CTRL_PSEL_LO] < 3'(N_PERIOD)) begin
                  period_sel <= HWDATA_IN[CTRL_PSEL_HI:CTRL_PSEL_LO];
               end
            end
            if (wr_ofs == OFS_START_PC) start_pc <= HWDATA_IN[PC_W-1:0];
            if (wr_ofs == OFS_SETTLE) settle_wait <= HWDATA_IN[CNT_W-1:0];
            for (int i = 0; i < N_PERIOD; i++) begin
               if (wr_ofs == OFS_PERIOD0 + 8'(4 * i)) period_slot[i] <= HWDATA_IN[CNT_W-1:0];
            end
            for (int i = 0; i < N_TARGET; i++) begin
               if (wr_ofs == OFS_TARGET0 + 8'(4 * i)) target_slot[i] <= HWDATA_IN[6:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);

   a_wake_two_cycles: assert property (wake_expire |=> state == ST_WAKE_A ##1 state == ST_WAKE_B ##1 state == ST_SETTLE)
      else $error("Wake sequence did not take two cycles.");
   a_stop_two_cycles: assert property (state == ST_EXEC && opc == OPC_STOP |=> state == ST_STOP_A ##1 state == ST_STOP_B ##1 state == ST_SLEEP)
      else $error("Stop sequence did not take two cycles.");
   a_settle_wait_held: assert property (state == ST_SETTLE && settle_cnt < settle_wait |=> state == ST_SETTLE)
      else $error("Program started before settle wait elapsed.");
   a_start_pc_used: assert property (state == ST_SETTLE ##1 state == ST_FETCH |-> pc == $past(start_pc))
      else $error("Program did not start at start address.");
   a_measure_route: assert property (state == ST_EXEC && opc == OPC_MEASURE && pad >= PAD_FIRST && pad <= PAD_LAST |=> MEAS_REQ_OUT.pad == $past(pad) - PAD_FIRST && MEAS_REQ_OUT.start == ($past(INSTR_IN[MEAS_SEL_BIT]) ? 2'h2 : 2'h1))
      else $error("Measurement routed to wrong converter or pad.");
   a_serial_read_data: assert property (SERIAL_REQ_OUT.start && !SERIAL_REQ_OUT.write |-> SERIAL_REQ_OUT.data == 8'h00)
      else $error("Serial read carries a data byte.");
   a_serial_target: assert property (state == ST_EXEC && opc == OPC_SERIAL |=> SERIAL_REQ_OUT.addr == $past(target_slot[INSTR_IN[SB_SLOT_HI:SB_SLOT_LO]]))
      else $error("Serial target address not from selected slot.");
   a_write_high_zero: assert property (PERIPH_REQ_OUT.wr |-> (PERIPH_REQ_OUT.wdata & ~PERIPH_REQ_OUT.wmask) == 32'h00000000 && (PERIPH_REQ_OUT.wdata >> $past(fld_low)) < 32'h00000100)
      else $error("Write data outside the eight-bit immediate.");
   a_sleep_no_count: assert property (state == ST_SLEEP && !ctrl_en |=> $stable(tick_cnt))
      else $error("Wake timer counted while disabled.");
   a_stall_fetch: assert property (state == ST_WAIT && !done_now |=> state == ST_WAIT && $stable(pc))
      else $error("Program advanced before transaction completed.");

endmodule

// ==== pkg/lpc_pkg.sv ====
// Package with constants, types and states of the coprocessor operation and wake block.
package lpc_pkg;
   // Opcodes and sub-fields.
   localparam logic [3:0] OPC_MEASURE = 4'h5;
   localparam logic [3:0] OPC_REG_RD = 4'h2;
   localparam logic [3:0] OPC_REG_WR = 4'h1;
   localparam logic [3:0] OPC_SERIAL = 4'h3;
   localparam logic [3:0] OPC_SYS = 4'h9;
   localparam logic [3:0] OPC_STOP = 4'hB;
   localparam logic [2:0] SYS_SLEEP_SEL = 3'h1;
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 28;
   localparam int SUB_HI = 27;
   localparam int SUB_LO = 25;
   // Measurement fields.
   localparam int MEAS_SEL_BIT = 6;
   localparam int MEAS_PAD_HI = 5;
   localparam int MEAS_PAD_LO = 2;
   localparam int DST_HI = 1;
   localparam int DST_LO = 0;
   localparam logic [3:0] PAD_FIRST = 4'h1;
   localparam logic [3:0] PAD_LAST = 4'hA;
   // Peripheral register fields.
   localparam int PR_HIGH_HI = 27;
   localparam int PR_HIGH_LO = 23;
   localparam int PR_LOW_HI = 22;
   localparam int PR_LOW_LO = 18;
   localparam int PR_IMM_HI = 17;
   localparam int PR_IMM_LO = 10;
   localparam int PR_ADDR_HI = 9;
   localparam int PR_ADDR_LO = 0;
   localparam logic [5:0] RD_SPAN_MAX = 6'h10;
   // Serial-bus fields.
   localparam int SB_SUB_HI = 7;
   localparam int SB_SUB_LO = 0;
   localparam int SB_DATA_HI = 15;
   localparam int SB_DATA_LO = 8;
   localparam int SB_SLOT_HI = 24;
   localparam int SB_SLOT_LO = 22;
   localparam int SB_DIR_BIT = 27;
   localparam int SLEEP_SEL_HI = 2;
   // Program-visible control word inside the peripheral window.
   localparam logic [9:0] CTRL_WORD_ADDR = 10'h000;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PSEL_LO = 4;
   localparam int CTRL_PSEL_HI = 6;
   // Bus register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_START_PC = 8'h04;
   localparam logic [7:0] OFS_SETTLE = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_PERIOD0 = 8'h10;
   localparam logic [7:0] OFS_TARGET0 = 8'h30;
   localparam logic [7:0] OFS_GREG0 = 8'h50;
   localparam int STATUS_PC_LO = 8;
   // Sizes and reset values.
   localparam int N_PERIOD = 5;
   localparam int N_TARGET = 8;
   localparam int N_GREG = 4;
   localparam int PC_W = 11;
   localparam int CNT_W = 16;
   localparam logic [15:0] PERIOD_RST = 16'h00C8;
   localparam logic [15:0] SETTLE_RST = 16'h0010;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [3:0] {
      ST_SLEEP = 4'h0,
      ST_WAKE_A = 4'h1,
      ST_WAKE_B = 4'h2,
      ST_SETTLE = 4'h3,
      ST_FETCH = 4'h4,
      ST_EXEC = 4'h5,
      ST_WAIT = 4'h6,
      ST_STOP_A = 4'h7,
      ST_STOP_B = 4'h8
   } lpc_state_t;

   typedef enum logic [1:0] {
      OP_MEAS = 2'h0,
      OP_SERIAL = 2'h1,
      OP_PERIPH = 2'h2
   } lpc_kind_t;

   typedef struct packed {
      logic [9:0] addr;
      logic [31:0] wdata;
      logic [31:0] wmask;
      logic wr;
      logic rd;
   } lpc_periph_req_t;

   typedef struct packed {
      logic [1:0] start;
      logic [3:0] pad;
   } lpc_meas_req_t;

   typedef struct packed {
      logic start;
      logic write;
      logic [6:0] addr;
      logic [7:0] sub;
      logic [7:0] data;
   } lpc_serial_req_t;
endpackage

// ==== verification/lpc_far.sv ====
// Far-side model: peripheral words, two converters and a serial master.
`timescale 1ns/10ps
module lpc_far
   import lpc_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire lpc_periph_req_t preq_in,
   input wire lpc_meas_req_t mreq_in,
   input wire lpc_serial_req_t sreq_in,
   output logic pack_out,
   output logic [31:0] prd_out,
   output logic mdone_out,
   output logic [15:0] mres_out,
   output logic sdone_out,
   output logic scl_out,
   output logic sda_out
);
   logic [31:0] regs [0:15];
   logic [3:0] dly;
   logic [3:0] a;
   logic [6:0] sk;
   logic [8:0] sbits;
   assign a = preq_in.addr[3:0];
   // A read answers on the wires: byte 5A, then the master's NACK, one bit per ten cycles; idle lines sit high.
   assign sda_out = sbits[8];
   // A serial write answer lags five cycles, so a fetch that does not stall shows up.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= 32'h5A5A0000 + 32'(i);
         end
         {pack_out, mdone_out, sdone_out, dly, prd_out, mres_out} <= '0;
         {scl_out, sbits, sk} <= {10'h3FF, 7'h00};
      end else begin
         pack_out <= preq_in.wr | preq_in.rd;
         prd_out <= regs[a] ^ {32{~preq_in.rd}};
         mdone_out <= |mreq_in.start;
         mres_out <= {8'hC0, 2'h0, mreq_in.start, mreq_in.pad};
         dly <= {dly[2:0], sreq_in.start & sreq_in.write};
         sdone_out <= dly[3] | (sk == 7'h01);
         if (sreq_in.start & ~sreq_in.write) begin
            {sk, sbits} <= {7'h5A, 9'h0B5};
         end else if (sk != 7'h00) begin
            sk <= sk - 7'h01;
            if (sk % 7'h0A == 7'h06) scl_out <= 1'h0;
            if (sk % 7'h0A == 7'h01) {scl_out, sbits} <= {1'h1, sbits[7:0], 1'h1};
         end
         if (preq_in.wr) begin
            regs[a] <= regs[a] & ~preq_in.wmask | preq_in.wdata;
         end
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// Bench for the coprocessor operation decoder and wake sequencer.
`timescale 1ns/10ps
module tb_top import lpc_pkg::*; ;
   logic clk = 1'h0, arst_n = 1'h0, hwrite = 1'h0, tick = 1'h0;
   logic [1:0] htrans = 2'h0, tdiv = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, instr = 32'h0, v, hrdata, prdata;
   logic [31:0] p [0:31] = '{default: 32'hB0000000};
   logic hready, fetch, awake, pack, mdone, sdone, scl, sda;
   logic [15:0] mres;
   logic [PC_W-1:0] pc;
   lpc_periph_req_t preq;
   lpc_meas_req_t mreq;
   lpc_serial_req_t sreq, seen;
   int n_errors = 0, checks = 0, nt = 0, nt0, n;
   lpc_io_wake dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .HSEL_IN(1'h1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
      .HREADYOUT_OUT(hready), .HRESP_OUT(), .INSTR_IN(instr), .PC_OUT(pc), .FETCH_OUT(fetch),
      .AWAKE_OUT(awake), .PERIPH_REQ_OUT(preq), .PERIPH_ACK_IN(pack), .PERIPH_RDATA_IN(prdata),
      .MEAS_REQ_OUT(mreq), .MEAS_DONE_IN(mdone), .MEAS_RESULT_IN(mres), .SERIAL_REQ_OUT(sreq),
      .SERIAL_DONE_IN(sdone), .SLOW_TICK_IN(tick), .SCL_IN(scl), .SDA_IN(sda));
   lpc_far far (.clk_in(clk), .arst_n_in(arst_n), .preq_in(preq), .mreq_in(mreq), .sreq_in(sreq),
      .pack_out(pack), .prd_out(prdata), .mdone_out(mdone), .mres_out(mres), .sdone_out(sdone),
      .scl_out(scl), .sda_out(sda));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      {tick, tdiv} <= {tick, tdiv} + 3'h1;
      nt <= nt + int'({tick, tdiv} == 3'h3);
      instr <= p[pc[4:0]];
      if (sreq.start === 1'h1) seen <= sreq;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
      {htrans, haddr, hwrite} <= {HTRANS_NONSEQ, ad, w};
      do @(posedge clk); while (hready !== 1'h1);
      {htrans, hwdata} <= {2'h0, d};
      do @(posedge clk); while (hready !== 1'h1);
      v = hrdata;
   endtask
   task automatic rd(input logic [31:0] ad, input logic [31:0] e);
      ahb(1'h0, ad, 32'h0);
      chk("read", v, e);
   endtask
   task automatic run(input logic [10:0] spc, input int tk);
      @(posedge awake);
      if (tk > 0) chk("ticks", nt - nt0, tk);
      for (n = 0; fetch !== 1'h1; n++) @(posedge clk) #1;
      chk("settle", n, 8);
      chk("pc", 32'(pc), 32'(spc));
      wait (awake === 1'h0);
      @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      p[4] = 32'h5000004E;
      p[5] = 32'h1593FC03;
      p[6] = 32'h1782AC05;
      p[7] = 32'h2FA00003;
      p[8] = 32'h39403C77;
      p[16] = 32'h31400012;
      p[17] = 32'h92000002;
      repeat (10) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      rd(32'h100, 32'h0);
      ahb(1'h1, 32'h44, 32'h2D);
      ahb(1'h1, 32'h04, 32'h4);
      ahb(1'h1, 32'h08, 32'h5);
      ahb(1'h1, 32'h14, 32'h3);
      // Enable just after a tick falls, so no tick straddles the enable.
      @(negedge tick);
      ahb(1'h1, 32'h00, 32'h1);
      nt0 = nt;
      run(11'h4, 200);
      rd(32'h58, 32'hC022);
      rd(32'h50, 32'h5A0F);
      chk("reg3", far.regs[3], 32'h5A5A0FF3);
      chk("reg5", far.regs[5], 32'h5A5A00AB);
      chk("swr", 32'(seen), 32'h1AD773C);
      ahb(1'h1, 32'h00, 32'h10);
      repeat (300) @(posedge clk);
      chk("awake", 32'(awake), 32'h0);
      ahb(1'h1, 32'h04, 32'h10);
      ahb(1'h1, 32'h00, 32'h11);
      run(11'h10, 0);
      rd(32'h00, 32'h21);
      ahb(1'h1, 32'h00, 32'h0);
      rd(32'h50, 32'h5A);
      chk("srd", 32'(seen), 32'h12D1200);
      print_verdict();
   end
   initial begin
      #100us;
      n_errors++;
      print_verdict();
   end
endmodule
